// [tmps_port_mode.sv]
// Overview of operation
// (R1) global choice: one high-speed stream or low-speed ports, never both
// (R2) high-speed stream forced to unstructured (unframed) mapping
// (R3) high-speed bit of global_config_zero set to one selects high speed
// (R4) low-speed ports each configured alone as E1, T1 or serial
// (R5) E1/T1 ports choose unframed, framed or multiframed; sync follows it
// (R6) two-clock mode: transmit on tx clock, receive on rx clock
// (R7) one-clock mode: both directions on tx clock, rx clock ignored
// (R8) each port has its own configuration register
// (R9) transmit data driven out on the port's tx clock
// (R10) receive data sampled as supplied with the receive clock
// (R11) far end supplies transmit frame sync per port
// (R12) shared pin: multiframe sync input or carrier detect output
// (R13) shared output: transmit signaling or clear to send
// (R14) far end supplies receive frame or multiframe sync
// (R15) far end drives receive signaling or request to send
// (R16) per-port recovered clock output
// (R17) up to eight ports indexed from one
// (R18) high-speed stream uses port one only
// (R19) line type picks sync/signaling or handshake pin function
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tmps_port_mode (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             core_high_speed,
  output logic      [8:1]  core_port_active,
  input  wire logic [8:1]  port_tx_clock,
  input  wire logic [8:1]  port_rx_clock,
  output logic      [8:1]  port_tx_data,
  input  wire logic [8:1]  port_tx_frame_sync,
  input  wire logic [8:1]  port_tx_mframe_or_carrier_i,
  output logic      [8:1]  port_tx_mframe_or_carrier_o,
  output logic      [8:1]  port_tx_mframe_or_carrier_oe,
  output logic      [8:1]  port_tx_sig_or_clear,
  input  wire logic [8:1]  port_rx_data,
  input  wire logic [8:1]  port_rx_frame_sync,
  input  wire logic [8:1]  port_rx_sig_or_request,
  output logic      [8:1]  port_recovered_clock,
  input  wire logic [8:1]  core_tx_data,
  input  wire logic [8:1]  core_tx_sig,
  input  wire logic [8:1]  core_clear_to_send,
  input  wire logic [8:1]  core_carrier_detect,
  output logic      [8:1]  core_tx_fsync,
  output logic      [8:1]  core_tx_mfsync,
  output logic      [8:1]  core_rx_data,
  output logic      [8:1]  core_rx_fsync,
  output logic      [8:1]  core_rx_sig,
  output logic      [8:1]  core_rx_request
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic                            hs_ff;
  logic [tmps_pkg::PCFG_W-1:0]     pcfg_ff [1:8];
  logic [31:0]                     rdata_ff;
  logic [31:0]                     nxt_rdata;
  logic [8:1]                      active_ff;
  logic                            port_hit;
  logic [3:0]                      port_idx;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // (R8) one config word per port
  assign port_hit = (reg_addr >= tmps_pkg::OFF_PORT_BASE) &&
                    (reg_addr <= tmps_pkg::OFF_PORT_LAST) &&
                    (reg_addr[1:0] == 2'h0);
  assign port_idx = {1'b0, reg_addr[4:2]} + 4'h1;

  // ----------------------------------------
  // global configuration
  // ----------------------------------------
  // (R3) high-speed select
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_ff <= tmps_pkg::GC_HS_RST;
    end else if (reg_wr && reg_addr == tmps_pkg::OFF_GLOBAL) begin
      hs_ff <= reg_wdata[tmps_pkg::GC_HS_BIT];
    end
  end

  // ----------------------------------------
  // port configuration
  // ----------------------------------------
  // (R8) per-port config write
  always_ff @(posedge clk_sys) begin
    for (int n = 1; n <= 8; n++) begin
      if (!rst_n) begin
        pcfg_ff[n] <= tmps_pkg::PC_RST;
      end else if (reg_wr && port_hit && port_idx == 4'(n)) begin
        pcfg_ff[n] <= reg_wdata[15:0] & tmps_pkg::PC_MASK;
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // (R8) read back, unmapped reads zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_addr == tmps_pkg::OFF_GLOBAL) begin
      nxt_rdata[tmps_pkg::GC_HS_BIT] = hs_ff;
    end else if (reg_addr == tmps_pkg::OFF_STATUS) begin
      nxt_rdata[7:0]                 = active_ff;
      nxt_rdata[tmps_pkg::ST_HS_BIT] = hs_ff;
    end else if (port_hit) begin
      nxt_rdata[15:0] = pcfg_ff[port_idx];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  logic hs_out_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_out_ff <= 1'b0;
    end else begin
      hs_out_ff <= hs_ff;
    end
  end

  assign reg_rdata        = rdata_ff;
  assign core_high_speed  = hs_out_ff;
  assign core_port_active = active_ff;

  // ----------------------------------------
  // per-port logic
  // ----------------------------------------
  // (R17) eight ports indexed from one
  for (genvar i = 1; i <= 8; i++) begin : g_port
    logic [1:0]  lt;
    logic [1:0]  fmt;
    logic        en;
    logic        act;
    logic        is_ser;
    logic [1:0]  eff_fmt;
    logic [4:0]  xcfg_ff;
    logic [7:0]  div_cnt_ff;
    logic        rclk_ff;

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    assign lt  = pcfg_ff[i][tmps_pkg::PC_LT_LSB +: 2];
    assign fmt = pcfg_ff[i][tmps_pkg::PC_FMT_LSB +: 2];
    assign en  = pcfg_ff[i][tmps_pkg::PC_EN_BIT];
    // (R1) (R18) high speed keeps port one only
    assign act = en && (!hs_ff || i == 1);
    // (R4) (R19) line type per port
    assign is_ser = (lt == tmps_pkg::LT_SER);
    // (R2) high speed runs unstructured
    assign eff_fmt = hs_ff ? tmps_pkg::FMT_UNF : fmt;

    // ----------------------------------------
    // configuration snapshot
    // ----------------------------------------
    // (R1) (R18) port active flag
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        active_ff[i] <= 1'b0;
      end else begin
        active_ff[i] <= act;
      end
    end

    // (R6) (R7) mode word for port domains
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        xcfg_ff <= 5'h00;
      end else begin
        xcfg_ff <= {pcfg_ff[i][tmps_pkg::PC_ONECLK_BIT],
                    is_ser, eff_fmt, act};
      end
    end

    // ----------------------------------------
    // recovered clock
    // ----------------------------------------
    // (R16) recovered clock divider
    always_ff @(posedge clk_sys) begin
      if (!rst_n || !act) begin
        div_cnt_ff <= 8'h00;
        rclk_ff    <= 1'b0;
      end else if (div_cnt_ff ==
                   pcfg_ff[i][tmps_pkg::PC_DIV_LSB +: 8]) begin
        div_cnt_ff <= 8'h00;
        rclk_ff    <= ~rclk_ff;
      end else begin
        div_cnt_ff <= div_cnt_ff + 8'h01;
      end
    end
    assign port_recovered_clock[i] = rclk_ff;

    // ----------------------------------------
    // transmit clock domain
    // ----------------------------------------
    logic       trst1_ff;
    logic       trst2_ff;
    logic [4:0] tcfg1_ff;
    logic [4:0] tcfg2_ff;
    logic       txd_ff;
    logic       tsig_ff;
    logic       cd_o_ff;
    logic       cd_oe_ff;
    logic       tfs_ff;
    logic       tmf_ff;
    logic       trxd_ff;
    logic       trfs_ff;
    logic       trsg_ff;
    logic       trrq_ff;

    // reset into the transmit domain
    always_ff @(posedge port_tx_clock[i]) begin
      trst1_ff <= rst_n;
      trst2_ff <= trst1_ff;
    end

    // quasi-static mode word into the transmit domain
    always_ff @(posedge port_tx_clock[i]) begin
      tcfg1_ff <= xcfg_ff;
      tcfg2_ff <= tcfg1_ff;
    end

    // (R9) transmit data
    always_ff @(posedge port_tx_clock[i]) begin
      if (!trst2_ff || !tcfg2_ff[0]) begin
        txd_ff <= 1'b0;
      end else begin
        txd_ff <= core_tx_data[i];
      end
    end

    // (R13) (R19) signaling or clear to send
    always_ff @(posedge port_tx_clock[i]) begin
      if (!trst2_ff || !tcfg2_ff[0]) begin
        tsig_ff <= 1'b0;
      end else begin
        tsig_ff <= tcfg2_ff[3] ? core_clear_to_send[i]
                               : core_tx_sig[i];
      end
    end

    // (R12) (R19) carrier detect drive
    always_ff @(posedge port_tx_clock[i]) begin
      if (!trst2_ff || !tcfg2_ff[0]) begin
        cd_o_ff  <= 1'b0;
        cd_oe_ff <= 1'b0;
      end else begin
        cd_o_ff  <= core_carrier_detect[i];
        cd_oe_ff <= tcfg2_ff[3];
      end
    end

    // ----------------------------------------
    // transmit syncs
    // ----------------------------------------
    // (R5) (R11) transmit sync follows format
    always_ff @(posedge port_tx_clock[i]) begin
      if (!trst2_ff || !tcfg2_ff[0] || tcfg2_ff[3]) begin
        tfs_ff <= 1'b0;
      end else begin
        tfs_ff <= (tcfg2_ff[2:1] != tmps_pkg::FMT_UNF) &&
                  port_tx_frame_sync[i];
      end
    end

    // (R5) (R12) multiframe sync only when multiframed
    always_ff @(posedge port_tx_clock[i]) begin
      if (!trst2_ff || !tcfg2_ff[0] || tcfg2_ff[3]) begin
        tmf_ff <= 1'b0;
      end else begin
        tmf_ff <= (tcfg2_ff[2:1] == tmps_pkg::FMT_MF) &&
                  port_tx_mframe_or_carrier_i[i];
      end
    end

    // ----------------------------------------
    // one-clock receive
    // ----------------------------------------
    // (R7) receive sampled on tx clock
    always_ff @(posedge port_tx_clock[i]) begin
      if (!trst2_ff || !tcfg2_ff[0] || !tcfg2_ff[4]) begin
        trxd_ff <= 1'b0;
        trfs_ff <= 1'b0;
        trsg_ff <= 1'b0;
        trrq_ff <= 1'b0;
      end else begin
        trxd_ff <= port_rx_data[i];
        trfs_ff <= !tcfg2_ff[3] &&
                   (tcfg2_ff[2:1] != tmps_pkg::FMT_UNF) &&
                   port_rx_frame_sync[i];
        trsg_ff <= !tcfg2_ff[3] && port_rx_sig_or_request[i];
        trrq_ff <= tcfg2_ff[3] && port_rx_sig_or_request[i];
      end
    end

    // ----------------------------------------
    // receive clock domain
    // ----------------------------------------
    logic       rrst1_ff;
    logic       rrst2_ff;
    logic [4:0] rcfg1_ff;
    logic [4:0] rcfg2_ff;
    logic       rrxd_ff;
    logic       rrfs_ff;
    logic       rrsg_ff;
    logic       rrrq_ff;

    // reset into the receive domain
    always_ff @(posedge port_rx_clock[i]) begin
      rrst1_ff <= rst_n;
      rrst2_ff <= rrst1_ff;
    end

    // quasi-static mode word into the receive domain
    always_ff @(posedge port_rx_clock[i]) begin
      rcfg1_ff <= xcfg_ff;
      rcfg2_ff <= rcfg1_ff;
    end

    // ----------------------------------------
    // two-clock receive
    // ----------------------------------------
    // (R6) (R10) (R14) (R15) receive on rx clock
    always_ff @(posedge port_rx_clock[i]) begin
      if (!rrst2_ff || !rcfg2_ff[0] || rcfg2_ff[4]) begin
        rrxd_ff <= 1'b0;
        rrfs_ff <= 1'b0;
        rrsg_ff <= 1'b0;
        rrrq_ff <= 1'b0;
      end else begin
        rrxd_ff <= port_rx_data[i];
        rrfs_ff <= !rcfg2_ff[3] &&
                   (rcfg2_ff[2:1] != tmps_pkg::FMT_UNF) &&
                   port_rx_frame_sync[i];
        rrsg_ff <= !rcfg2_ff[3] && port_rx_sig_or_request[i];
        rrrq_ff <= rcfg2_ff[3] && port_rx_sig_or_request[i];
      end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign port_tx_data[i]                 = txd_ff;
    assign port_tx_sig_or_clear[i]         = tsig_ff;
    assign port_tx_mframe_or_carrier_o[i]  = cd_o_ff;
    assign port_tx_mframe_or_carrier_oe[i] = cd_oe_ff;
    assign core_tx_fsync[i]                = tfs_ff;
    assign core_tx_mfsync[i]               = tmf_ff;
    // (R7) one-clock ports never see stale rx-clock flops
    assign core_rx_data[i]                 = xcfg_ff[4] ? trxd_ff : rrxd_ff;
    assign core_rx_fsync[i]                = xcfg_ff[4] ? trfs_ff : rrfs_ff;
    assign core_rx_sig[i]                  = xcfg_ff[4] ? trsg_ff : rrsg_ff;
    assign core_rx_request[i]              = xcfg_ff[4] ? trrq_ff : rrrq_ff;
  end

endmodule
`default_nettype wire

// [tmps_pkg.sv]
package tmps_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned PCFG_W    = 16;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_GLOBAL    = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_PORT_BASE = 8'h20;
  localparam logic [7:0] OFF_PORT_LAST = 8'h3c;
  // ----------------------------------------
  // global_config_zero fields
  // ----------------------------------------
  localparam int unsigned GC_HS_BIT = 0;
  localparam logic        GC_HS_RST = 1'b0;
  // ----------------------------------------
  // port config fields
  // ----------------------------------------
  localparam int unsigned PC_LT_LSB     = 0;
  localparam int unsigned PC_FMT_LSB    = 2;
  localparam int unsigned PC_ONECLK_BIT = 4;
  localparam int unsigned PC_EN_BIT     = 5;
  localparam int unsigned PC_DIV_LSB    = 8;
  localparam logic [15:0] PC_RST        = 16'h0000;
  localparam logic [15:0] PC_MASK       = 16'hff3f;
  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int unsigned ST_HS_BIT = 8;
  // ----------------------------------------
  // modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    LT_E1  = 2'b00,
    LT_T1  = 2'b01,
    LT_SER = 2'b10
  } tmps_line_t;
  typedef enum logic [1:0] {
    FMT_UNF = 2'b00,
    FMT_FRM = 2'b01,
    FMT_MF  = 2'b10
  } tmps_fmt_t;
endpackage

// [tmps_port_mode_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module tmps_port_mode_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        core_high_speed,
  input wire logic [8:1]  core_port_active,
  input wire logic [8:1]  port_tx_clock,
  input wire logic [8:1]  port_tx_data,
  input wire logic [8:1]  port_tx_mframe_or_carrier_o,
  input wire logic [8:1]  port_tx_mframe_or_carrier_oe,
  input wire logic [8:1]  port_tx_sig_or_clear,
  input wire logic [8:1]  port_recovered_clock,
  input wire logic [8:1]  core_tx_data,
  input wire logic [8:1]  core_clear_to_send,
  input wire logic [8:1]  core_carrier_detect,
  input wire logic [8:1]  core_tx_fsync,
  input wire logic [8:1]  core_rx_fsync
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_RD_IDLE: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  AST_HS_SET: assert property (reg_wr && reg_addr == 8'h00 &&
    reg_wdata[0] |-> ##2 core_high_speed) else $error("high speed late");
  AST_HS_PORTS: assert property (core_high_speed &&
    $past(core_high_speed) |-> core_port_active[8:2] == 7'h00)
    else $error("low speed port active in high speed");
  AST_HS_UNFRAMED: assert property (core_high_speed [*8] |->
    !core_rx_fsync[1] && !core_tx_fsync[1]) else $error("sync in high speed");
  AST_RCLK_IDLE: assert property ((!core_port_active[2]) [*3] |->
    !port_recovered_clock[2]) else $error("recovered clock on idle port");
  AST_TX_DATA: assert property (@(posedge port_tx_clock[1])
    disable iff (!rst_n) core_port_active[1] && $past(core_port_active[1], 4)
    |-> port_tx_data[1] == $past(core_tx_data[1])) else $error("tx data");
  AST_CTS: assert property (@(posedge port_tx_clock[2])
    disable iff (!rst_n) port_tx_mframe_or_carrier_oe[2] &&
    $past(port_tx_mframe_or_carrier_oe[2], 2) |->
    port_tx_sig_or_clear[2] == $past(core_clear_to_send[2]))
    else $error("clear to send");
  AST_CARRIER: assert property (@(posedge port_tx_clock[2])
    disable iff (!rst_n) port_tx_mframe_or_carrier_oe[2] &&
    $past(port_tx_mframe_or_carrier_oe[2], 2) |->
    port_tx_mframe_or_carrier_o[2] == $past(core_carrier_detect[2]))
    else $error("carrier detect");
  cover property (core_high_speed);
  cover property (reg_rd ##1 reg_rdata != 32'h0);
  cover property (@(posedge port_tx_clock[2]) port_tx_mframe_or_carrier_oe[2]);
endmodule
bind tmps_port_mode tmps_port_mode_chk tmps_port_mode_chk_i (.clk_sys,
  .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .core_high_speed, .core_port_active, .port_tx_clock, .port_tx_data,
  .port_tx_mframe_or_carrier_o, .port_tx_mframe_or_carrier_oe,
  .port_tx_sig_or_clear, .port_recovered_clock, .core_tx_data,
  .core_clear_to_send, .core_carrier_detect, .core_tx_fsync, .core_rx_fsync);
`default_nettype wire

// [tmps_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tmps_line_model #(
  parameter bit INV = 1'b0
) (
  input  wire logic tx_clock,
  input  wire logic carrier_oe,
  output logic      rx_data,
  output logic      rx_sync,
  output logic      rx_sig,
  output logic      tx_sync,
  output logic      mf_drv,
  output logic      mf_en
);
  logic [3:0] cnt_ff = 4'h0;
  initial {rx_data, rx_sync, rx_sig, tx_sync, mf_drv, mf_en} = 6'h00;
  always @(negedge tx_clock) begin
    cnt_ff  <= cnt_ff + 4'h1;
    rx_data <= cnt_ff[0] ^ cnt_ff[2] ^ INV;
    rx_sync <= cnt_ff[2:0] == 3'h0;
    rx_sig  <= cnt_ff[1] ^ INV;
    tx_sync <= cnt_ff[2:0] == 3'h3;
    mf_drv  <= cnt_ff == 4'h5;
    mf_en   <= !carrier_oe;
  end
endmodule
`default_nettype wire

// [tmps_port_mode_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tmps_port_mode_tb_top;
  logic        clk_sys = 1'b0, rst_n = 1'b0, txc = 1'b0, rxc = 1'b0;
  logic        rx_run = 1'b1, hs_on = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        hs;
  logic [8:1]  act, p_txd, mf_o, mf_oe, sg_cl, rec, c_fs, c_mfs;
  logic [8:1]  c_rxd, c_rfs, c_rsg, c_rrq, ph = 8'h00;
  logic [8:1]  c_txd = 8'h00, c_tsg = 8'h00, c_cts = 8'h00, c_cd = 8'h00;
  wire  [8:1]  rxd, rfs, rsg, tfs, mfd, mfe, mf_pin, prc;
  logic [15:0] cfg [1:8];
  int          err_total = 0, compares = 0;
  always #10 clk_sys = ~clk_sys;
  always #7.5 txc = ~txc;
  initial begin
    #3;
    forever #7.5 rxc = ~rxc;
  end
  assign prc = rx_run ? {8{rxc}} : 8'h00;
  assign mf_pin = (mf_oe & mf_o) | (~mf_oe & mfe & mfd);
  for (genvar g = 1; g <= 8; g++) begin : g_line
    tmps_line_model #(.INV(g % 2)) tmps_line_model_i (.tx_clock(txc),
      .carrier_oe(mf_oe[g]), .rx_data(rxd[g]), .rx_sync(rfs[g]),
      .rx_sig(rsg[g]), .tx_sync(tfs[g]), .mf_drv(mfd[g]), .mf_en(mfe[g]));
  end
  tmps_port_mode tmps_port_mode_i (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .core_high_speed(hs),
    .core_port_active(act), .port_tx_clock({8{txc}}), .port_rx_clock(prc),
    .port_tx_data(p_txd), .port_tx_frame_sync(tfs),
    .port_tx_mframe_or_carrier_i(mf_pin), .port_tx_mframe_or_carrier_o(mf_o),
    .port_tx_mframe_or_carrier_oe(mf_oe), .port_tx_sig_or_clear(sg_cl),
    .port_rx_data(rxd), .port_rx_frame_sync(rfs),
    .port_rx_sig_or_request(rsg), .port_recovered_clock(rec),
    .core_tx_data(c_txd), .core_tx_sig(c_tsg), .core_clear_to_send(c_cts),
    .core_carrier_detect(c_cd), .core_tx_fsync(c_fs), .core_tx_mfsync(c_mfs),
    .core_rx_data(c_rxd), .core_rx_fsync(c_rfs), .core_rx_sig(c_rsg),
    .core_rx_request(c_rrq));
  task automatic chk(input string nm, input logic [31:0] got, e);
    compares++;
    if (got !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask
  // ----
  // per-port link check
  // ----
  task automatic link;
    logic [8:1] sd, sf, ss, tf, mf, td, ts, cs, cd;
    logic       a, s, f;
    repeat (20) begin
      @(posedge txc);
      {sd, sf, ss, tf, mf} = {rxd, rfs, rsg, tfs, mf_pin};
      {td, ts, cs, cd} = {c_txd, c_tsg, c_cts, c_cd};
      {c_txd, c_tsg, c_cts, c_cd, ph} <= {~c_txd ^ ph, ph, ~ph, c_txd, ph + 8'h1d};
      #4;
      for (int n = 1; n <= 8; n++) begin
        a = cfg[n][5] && (!hs_on || n == 1);
        s = cfg[n][1:0] == 2'b10;
        f = !s && cfg[n][3:2] != 2'b00 && !hs_on;
        chk("tx_data", p_txd[n], a & td[n]);
        chk("sig_clear", sg_cl[n], a & (s ? cs[n] : ts[n]));
        chk("carrier_oe", mf_oe[n], a & s);
        chk("carrier", mf_o[n], a & cd[n]);
        chk("tx_fsync", c_fs[n], a & f & tf[n]);
        chk("tx_mfsync", c_mfs[n], a & f & cfg[n][3] & mf[n]);
        if (rx_run || cfg[n][4]) begin
          chk("rx_data", c_rxd[n], a & sd[n]);
          chk("rx_fsync", c_rfs[n], a & f & sf[n]);
          chk("rx_sig", c_rsg[n], a & !s & ss[n]);
          chk("rx_request", c_rrq[n], a & s & ss[n]);
        end
      end
    end
  endtask
  task automatic rclk(input int n);
    logic v;
    int   c;
    for (int k = 0; k < 2; k++) begin
      v = rec[n];
      c = 0;
      while (rec[n] === v && c < 600) begin
        @(posedge clk_sys);
        #1;
        c++;
      end
    end
    if (c >= 600) begin
      err_total++;
      end_sim;
    end else begin
      chk("rec_clock", c, {24'h0, cfg[n][15:8]} + 32'h1);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0000ff3f);
    for (int n = 1; n <= 8; n++) begin
      cfg[n] = {8'(n + 1), 2'b00, n != 8, n[1], 2'((n / 3) % 3), 2'(n % 3)};
      wr(8'h20 + 8'(4 * (n - 1)), {16'h0, cfg[n]});
    end
    for (int n = 1; n <= 8; n++) begin
      rd(8'h20 + 8'(4 * (n - 1)), {16'h0, cfg[n]});
    end
    rd(8'h04, 32'h0000007f);
    link();
    rx_run <= 1'b0;
    link();
    rx_run <= 1'b1;
    rclk(1);
    rclk(5);
    cfg[1][3:2] = 2'b10;
    wr(8'h20, {16'h0, cfg[1]});
    wr(8'h00, 32'h1);
    hs_on = 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(8'h04, 32'h00000101);
    chk("high_speed", hs, 32'h1);
    chk("port_active", act, 32'h01);
    link();
    wr(8'h00, 32'h0);
    hs_on = 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(8'h04, 32'h0000007f);
    chk("high_speed", hs, 32'h0);
    chk("port_active", act, 32'h7f);
    end_sim;
  end
endmodule
`default_nettype wire
